// *** rtl/can_timing_regs.svh ***
`ifndef CAN_TIMING_REGS_SVH
`define CAN_TIMING_REGS_SVH
`define ADDR_ERROR_COUNTERS    4'h0
`define ADDR_BIT_TIMING_ONE    4'h1
`define TX_ERR_MSB             15
`define TX_ERR_LSB             8
`define RX_ERR_MSB             7
`define RX_ERR_LSB             0
`define SJW_MSB                7
`define SJW_LSB                6
`define PRESC_MSB              5
`define PRESC_LSB              0
`define CFG_ONE_RESET          16'h0000
`define SJQ_CODE_11            3'h4
`define SJQ_CODE_10            3'h3
`define SJQ_CODE_01            3'h2
`define SJQ_CODE_00            3'h1
`define SJQ_RESET              3'h1
`define RDATA_IDLE             16'h0000
`define UNUSED_BYTE            8'h00
`define DIV_CNT_RESET          7'h00
`define DIV_CNT_STEP           7'h01
`endif

// *** rtl/can_timing_pkg.sv ***
`default_nettype none
package can_timing_pkg;
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;
    typedef struct packed {
        logic [1:0] sync_jump_width;
        logic [5:0] quantum_prescaler;
    } bit_timing_s;
endpackage
`default_nettype wire

// *** rtl/can_bit_timing_error_count.sv ***
// Summary of operation
// - Tx error count in bits 15..8
// - Rx error count in bits 7..0
// - Config bits 15..8 read zero, ignore writes
// - Jump width codes 11,10,01 give 4,3,2
// - Quantum lasts 2*(prescaler+1) clocks
//
// Implementation choices: the placing of the registers and the strobed register port.

// Register slice of a CAN controller: error counts and bit timing
// Register map, one 16-bit word per index:
//   Index 0, error counters, read only
//     Bits 15..8 transmit count, bits 7..0 receive count
//     Writes to this index are dropped
//   Index 1, bit timing config one, read and write
//     Bits 15..8 not stored, read as zero
//     Bits 7..6 jump width code, bits 5..0 quantum prescaler
//   Other indexes read zero and drop writes
//
// Register port timing:
//   A strobe is taken on the rising edge that sees it high
//   Read data stand in the following cycle only, zero otherwise
//   A write changes the config on that same edge
//   Write and read strobes may follow each other with no gap
//
// Derived outputs:
//   Jump width in quanta follows the config one cycle late
//   Time quantum is a one-cycle pulse every 2*(prescaler+1) clocks
//   A new prescaler applies at once; the running quantum may be cut
//
// Counters come from the protocol engine on this clock, so they are
// read without synchronisers
//
// Reset:
//   Config clears to zero, so jump width is one quantum and the
//   quantum pulse runs at its fastest, every second clock
//   Read data and the quantum pulse are low during reset

`include "can_timing_regs.svh"
`default_nettype none
module can_bit_timing_error_count #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // Register port
    input  wire can_timing_pkg::reg_req_s req,
    output logic [15:0]                  rdata,
    // Protocol engine side
    input  wire logic [CNT_W-1:0]        tx_error_counter,
    input  wire logic [CNT_W-1:0]        rx_error_counter,
    output logic [2:0]                   sync_jump_quanta,
    output logic                         time_quantum
);
    import can_timing_pkg::*;

    // Widths used by the register map and the divider
    // Register word
    localparam int REG_W = 16;
    // Stored config payload
    localparam int CFG_W = $bits(bit_timing_s);
    // Divider counts up to 2*63+1
    localparam int DIV_W = 7;
    // Jump width up to four quanta
    localparam int SJQ_W = 3;

    // The map packs both counters into one word and the config into a
    // byte, so other widths cannot be served
    if (CNT_W != 8) begin : g_bad_cnt_w
        $error("CNT_W must be 8");
    end
    if (CFG_W != 8) begin : g_bad_cfg_w
        $error("Config payload must be 8 bits");
    end

    // Reset image of the config register; only its lower byte is stored
    localparam logic [REG_W-1:0] CFG_RESET_WORD = `CFG_ONE_RESET;
    localparam bit_timing_s      CFG_RESET      =
        bit_timing_s'(CFG_RESET_WORD[CFG_W-1:0]);

    // Jump width in quanta for a two-bit code
    function automatic logic [SJQ_W-1:0] jump_quanta(
        input logic [1:0] code
    );
        logic [SJQ_W-1:0] q;
        case (code)
            2'b11:   q = `SJQ_CODE_11;
            2'b10:   q = `SJQ_CODE_10;
            2'b01:   q = `SJQ_CODE_01;
            default: q = `SJQ_CODE_00;
        endcase
        return q;
    endfunction

    // Last divider count: counting 0 up to 2*p+1 gives 2*(p+1) clocks
    function automatic logic [DIV_W-1:0] quantum_last(
        input logic [5:0] presc
    );
        return {presc, 1'b1};
    endfunction

    // Error count word: transmit byte above receive byte
    function automatic logic [REG_W-1:0] error_word(
        input logic [CNT_W-1:0] tx,
        input logic [CNT_W-1:0] rx
    );
        logic [REG_W-1:0] w;
        // Start from zero so no bit is left undriven
        w = `RDATA_IDLE;
        w[`TX_ERR_MSB:`TX_ERR_LSB] = tx;
        w[`RX_ERR_MSB:`RX_ERR_LSB] = rx;
        return w;
    endfunction

    // Config word: the unimplemented upper byte always reads zero
    function automatic logic [REG_W-1:0] config_word(
        input bit_timing_s c
    );
        return {`UNUSED_BYTE, c};
    endfunction

    // Strobe decode for the two mapped registers
    logic        cfg_write;
    logic        err_read;
    logic        cfg_read;

    // Writes to the error counters index have no target
    assign cfg_write = req.wr && (req.addr == `ADDR_BIT_TIMING_ONE);
    // Reads of unmapped indexes match neither line
    assign err_read  = req.rd && (req.addr == `ADDR_ERROR_COUNTERS);
    assign cfg_read  = req.rd && (req.addr == `ADDR_BIT_TIMING_ONE);

    // Config register
    bit_timing_s cfg;
    bit_timing_s next_cfg;

    always_comb begin
        next_cfg = cfg;
        if (cfg_write) begin
            // Upper byte of the write data has nowhere to go
            next_cfg.sync_jump_width   = req.wdata[`SJW_MSB:`SJW_LSB];
            next_cfg.quantum_prescaler = req.wdata[`PRESC_MSB:`PRESC_LSB];
        end
    end

    // Config flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    // Read data: registered, stands for the one cycle after the strobe
    // and drops back to zero so a stale word is never mistaken for new
    logic [REG_W-1:0] next_rdata;

    always_comb begin
        next_rdata = `RDATA_IDLE;
        if (err_read) begin
            // Counters are taken as they stand at the read edge
            next_rdata = error_word(tx_error_counter, rx_error_counter);
        end else if (cfg_read) begin
            next_rdata = config_word(cfg);
        end
        // Unmapped indexes and idle cycles keep the zero word
    end

    // Read data flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= `RDATA_IDLE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Jump width, registered one cycle after the config changes
    logic [SJQ_W-1:0] next_sjq;

    always_comb begin
        // Code 00 maps to a single quantum
        next_sjq = jump_quanta(cfg.sync_jump_width);
    end

    // Jump width flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_jump_quanta <= `SJQ_RESET;
        end else begin
            sync_jump_quanta <= next_sjq;
        end
    end

    // Quantum divider
    // A new prescaler takes effect at once: a count already past the new
    // limit wraps on the next clock instead of running the long way round
    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] next_div_cnt;
    logic [DIV_W-1:0] div_last;
    logic             next_tq;

    always_comb begin
        div_last = quantum_last(cfg.quantum_prescaler);
        // Wrap and pulse at the last count
        if (div_cnt >= div_last) begin
            next_div_cnt = `DIV_CNT_RESET;
            next_tq      = 1'b1;
        end else begin
            next_div_cnt = div_cnt + `DIV_CNT_STEP;
            next_tq      = 1'b0;
        end
    end

    // Divider flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt      <= `DIV_CNT_RESET;
            time_quantum <= 1'b0;
        end else begin
            div_cnt      <= next_div_cnt;
            time_quantum <= next_tq;
        end
    end
endmodule // can_bit_timing_error_count
`default_nettype wire

// *** bench/can_bit_timing_error_count_properties.sv ***
`default_nettype none
module tq_chk import can_timing_pkg::*; #(parameter int CNT_W = 8) (
    input wire logic core_clk, rst_n, input wire reg_req_s req,
    input wire logic [15:0] rdata, input wire logic [2:0] sync_jump_quanta,
    input wire logic [CNT_W-1:0] tx_error_counter, rx_error_counter,
    input wire logic time_quantum);
    timeunit 1ns; timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_tx_byte: assert property (req.rd && req.addr == 4'h0 |=>
        rdata[15:8] == $past(tx_error_counter)) else $error("tx byte");
    chk_rx_byte: assert property (req.rd && req.addr == 4'h0 |=>
        rdata[7:0] == $past(rx_error_counter)) else $error("rx byte");
    chk_cfg_top: assert property (req.rd && req.addr == 4'h1 |=>
        rdata[15:8] == 8'h00) else $error("cfg top");
    chk_jump_width: assert property (req.wr && req.addr == 4'h1 |=>
        ##1 sync_jump_quanta == 3'($past(req.wdata[7:6], 2)) + 3'h1)
        else $error("jump width");
    chk_quantum_pulse: assert property (time_quantum |=>
        !time_quantum) else $error("quantum pulse");
    chk_unmapped_zero: assert property (req.rd && req.addr > 4'h1 |=>
        rdata == 16'h0000) else $error("unmapped read");
endmodule // tq_chk
`default_nettype wire

// *** bench/err_source.sv ***
`default_nettype none
module err_source (input wire logic core_clk, step,
    output logic [7:0] tx, output wire logic [7:0] rx);
    timeunit 1ns; timeprecision 1ns;
    initial tx = 8'h00;
    always @(posedge core_clk) if (step) tx <= tx + 8'h11;
    assign rx = ~tx;
endmodule // err_source
`default_nettype wire

// *** bench/can_bit_timing_error_count_tb_top.sv ***
`default_nettype none
module can_bit_timing_error_count_tb_top;
    timeunit 1ns; timeprecision 100ps;
    logic core_clk = 0, rst_n = 0, step = 0, tq;
    can_timing_pkg::reg_req_s req = '0;
    logic [15:0] rdata; logic [7:0] tx, rx; logic [2:0] sjq;
    int n_errors = 0, n_compared = 0, cyc = 0, n;
    err_source far (.core_clk, .step, .tx, .rx);
    can_bit_timing_error_count uut (.core_clk, .rst_n, .req, .rdata,
        .tx_error_counter(tx), .rx_error_counter(rx),
        .sync_jump_quanta(sjq), .time_quantum(tq));
    task automatic cmp(logic [15:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t %h %h", $time, s, e);
        end
    endtask
    task automatic acc(logic w, logic [3:0] a, logic [15:0] d);
        @(posedge core_clk) req <= '{a, d, w, !w};
        @(posedge core_clk) req <= '0;
        #1;
    endtask
    task automatic results;
        if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc == 3000) begin
        n_errors++;
        results;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1;
        #1 cmp(16'(sjq), 16'h0001);
        acc(1, 4'h1, 16'hFFFF);
        acc(0, 4'h1, '0);
        cmp(rdata, 16'h00FF);
        for (int c = 0; c < 4; c++) begin
            acc(1, 4'h1, 16'(c * 85));
            @(posedge core_clk) #1 cmp(16'(sjq), 16'(c + 1));
            repeat (2) do @(posedge core_clk) #1; while (!tq);
            n = 0;
            do begin @(posedge core_clk) #1; n++; end while (!tq);
            cmp(16'(n), 16'(c * 42 + 2));
        end
        @(posedge core_clk);
        step <= 1;
        repeat (3) @(posedge core_clk);
        step <= 0;
        acc(0, 4'h0, '0);
        cmp(rdata, 16'h33CC);
        acc(0, 4'h9, '0);
        cmp(rdata, 16'h0000);
        results;
    end
endmodule // can_bit_timing_error_count_tb_top
bind can_bit_timing_error_count tq_chk #(.CNT_W(CNT_W)) chk (.core_clk,
    .rst_n, .req, .rdata, .sync_jump_quanta, .tx_error_counter,
    .rx_error_counter, .time_quantum);
`default_nettype wire
